// ==== verilog/hopreg_consts.svh ====
`ifndef HOPREG_CONSTS_SVH
`define HOPREG_CONSTS_SVH
`define HOPREG_ADDR_W        7
`define HOPREG_DATA_W        8
`define HOPREG_FREQ_W        24
`define HOPREG_ADR_HOP_CH    7'h79
`define HOPREG_ADR_HOP_STEP  7'h7A
`define HOPREG_ADR_TA_LEN    7'h7B
`define HOPREG_ADR_RX_THR    7'h7E
`define HOPREG_ADR_FIFO      7'h7F
`define HOPREG_RST_HOP_CH    8'h00
`define HOPREG_RST_HOP_STEP  8'h00
`define HOPREG_RST_TA_LEN    8'h7B
`define HOPREG_RST_RX_THR    6'h00
`define HOPREG_LEN_COMP_BIT  7
`define HOPREG_TA_EN_BIT     2
`define HOPREG_PHASE_HI      1
`define HOPREG_PHASE_LO      0
`define HOPREG_THR_W         6
`define HOPREG_HOP_UNIT_KHZ  5'h0A
`define HOPREG_CRC_BYTES     8'h02
`define HOPREG_BUF_DEPTH     2
`endif

// ==== verilog/hopreg_pkg.sv ====
package hopreg_pkg;
`include "hopreg_consts.svh"

	// frame state, cleared while select is high
	typedef struct packed {
		logic                          addr_phase;
		logic [2:0]                    bit_cnt;
		logic                          rw;
		logic [`HOPREG_ADDR_W-1:0]     addr;
		logic [6:0]                    shin;
		logic [`HOPREG_DATA_W-1:0]     shout;
	} hopreg_frame_t;

	// words handed to the system side, held stable between toggles
	typedef struct packed {
		logic [`HOPREG_ADDR_W-1:0]     wr_addr;
		logic [`HOPREG_DATA_W-1:0]     wr_data;
		logic                          wr_tgl;
		logic [`HOPREG_ADDR_W-1:0]     rd_addr;
		logic                          rd_pop;
		logic                          rd_tgl;
	} hopreg_evt_t;

	typedef struct packed {
		logic [2:0]                    wr_sync;
		logic [2:0]                    rd_sync;
		logic                          load_pend;
		logic                          held_valid;
		logic [`HOPREG_DATA_W-1:0]     rd_hold;
		logic [`HOPREG_DATA_W-1:0]     hop_ch;
		logic [`HOPREG_DATA_W-1:0]     hop_step;
		logic [`HOPREG_DATA_W-1:0]     ta_len;
		logic [`HOPREG_THR_W-1:0]      rx_thr;
		logic [`HOPREG_FREQ_W-1:0]     carrier;
		logic [`HOPREG_DATA_W-1:0]     payload;
		logic [`HOPREG_DATA_W-1:0]     frame;
		logic                          ta_fired;
		logic                          ta_pulse;
		logic                          irq_n;
		logic                          almost_full;
	} hopreg_sys_t;
endpackage

// ==== verilog/hopreg_buf2.sv ====
`timescale 1ns/10ps
module hopreg_buf2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic                         clk_sys,
	input  wire logic                         reset,
	input  wire logic [WIDTH-1:0]             in_data,
	input  wire logic                         in_valid,
	output logic                              in_ready,
	output logic [WIDTH-1:0]                  out_data,
	output logic                              out_valid,
	input  wire logic                         out_ready,
	output logic [$clog2(DEPTH+1)-1:0]        level
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int LW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0]  mem;
		logic [PW-1:0]                wp;
		logic [PW-1:0]                rp;
		logic [LW-1:0]                cnt;
	} hopreg_buf_t;

	hopreg_buf_t st_ff;
	hopreg_buf_t nxt_st;
	logic        push;
	logic        pop;

	assign in_ready  = (st_ff.cnt != LW'(DEPTH));
	assign out_valid = (st_ff.cnt != '0);
	assign out_data  = st_ff.mem[st_ff.rp];
	assign level     = st_ff.cnt;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		nxt_st = st_ff;
		if (push)
		begin
			nxt_st.mem[st_ff.wp] = in_data;
			nxt_st.wp = (st_ff.wp == PW'(DEPTH-1)) ? '0 : st_ff.wp + PW'(1);
		end
		if (pop)
			nxt_st.rp = (st_ff.rp == PW'(DEPTH-1)) ? '0 : st_ff.rp + PW'(1);
		if (push && !pop)
			nxt_st.cnt = st_ff.cnt + LW'(1);
		else if (pop && !push)
			nxt_st.cnt = st_ff.cnt - LW'(1);
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule

// ==== verilog/hopreg_top.sv ====
`timescale 1ns/10ps
`include "hopreg_consts.svh"

module hopreg_top #(
	parameter int BUF_DEPTH = `HOPREG_BUF_DEPTH
) (
	input  wire logic                         clk_sys,
	input  wire logic                         reset,
	input  wire logic                         spi_sclk,
	input  wire logic                         serial_select_n,
	input  wire logic                         spi_sdi,
	output logic                              spi_sdo,
	input  wire logic [`HOPREG_DATA_W-1:0]    rx_data,
	input  wire logic                         rx_valid,
	output logic                              rx_ready,
	input  wire logic [`HOPREG_FREQ_W-1:0]    nominal_khz,
	input  wire logic [`HOPREG_DATA_W-1:0]    pkt_len,
	input  wire logic                         crc_enable,
	input  wire logic                         last_byte,
	input  wire logic [2:0]                   bit_index,
	input  wire logic [7:0]                   irq_status,
	input  wire logic [7:0]                   irq_enable,
	output logic                              interrupt_out_n,
	output logic [`HOPREG_FREQ_W-1:0]         carrier_khz,
	output logic [`HOPREG_DATA_W-1:0]         payload_len,
	output logic [`HOPREG_DATA_W-1:0]         frame_len,
	output logic                              turnaround_pulse,
	output logic                              rx_almost_full
);
	import hopreg_pkg::*;

	localparam int LW = $clog2(BUF_DEPTH+1);

	hopreg_pkg::hopreg_frame_t frame_ff;
	hopreg_pkg::hopreg_frame_t nxt_frame;
	hopreg_pkg::hopreg_evt_t   evt_ff;
	hopreg_pkg::hopreg_evt_t   nxt_evt;
	hopreg_pkg::hopreg_sys_t   sys_ff;
	hopreg_pkg::hopreg_sys_t   nxt_sys;

	logic [`HOPREG_ADDR_W-1:0] next_addr;
	logic [`HOPREG_DATA_W-1:0] buf_data;
	logic                      buf_valid;
	logic                      buf_pop;
	logic [LW-1:0]             buf_level;
	logic                      wr_ev;
	logic                      rd_ev;
	logic                      ta_hit;
	logic [20:0]               hop_khz;
	logic [7:0]                irq_hit;
	logic [3:0]                wr_hit;
	logic [`HOPREG_DATA_W-1:0] rd_view;
	logic [`HOPREG_DATA_W-1:0] len_frame;
	logic [`HOPREG_DATA_W-1:0] len_payload;

	// writable registers in decoder order; the fifo port takes no writes
	localparam logic [`HOPREG_ADDR_W-1:0] REG_ADR [4] = '{
		`HOPREG_ADR_HOP_CH,
		`HOPREG_ADR_HOP_STEP,
		`HOPREG_ADR_TA_LEN,
		`HOPREG_ADR_RX_THR
	};

	hopreg_buf2 #(
		.WIDTH (`HOPREG_DATA_W),
		.DEPTH (BUF_DEPTH)
	) u_rx_buf (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.in_data   (rx_data),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (buf_pop),
		.level     (buf_level)
	);

	// fifo address does not advance, so a burst keeps draining it
	assign next_addr = (frame_ff.addr == `HOPREG_ADR_FIFO) ?
		frame_ff.addr : frame_ff.addr + 7'h01;

	// link side, runs only on serial clock edges inside a frame
	always_comb
	begin
		nxt_frame = frame_ff;
		nxt_evt = evt_ff;
		nxt_frame.bit_cnt = frame_ff.bit_cnt + 3'h1;
		if (frame_ff.addr_phase)
		begin
			nxt_frame.shin = {frame_ff.shin[5:0], spi_sdi};
			if (frame_ff.bit_cnt == 3'h7)
			begin
				nxt_frame.addr_phase = 1'b0;
				nxt_frame.rw = frame_ff.shin[6];
				nxt_frame.addr = {frame_ff.shin[5:0], spi_sdi};
				if (!frame_ff.shin[6])
				begin
					nxt_evt.rd_addr = {frame_ff.shin[5:0], spi_sdi};
					nxt_evt.rd_pop = 1'b0;
					nxt_evt.rd_tgl = ~evt_ff.rd_tgl;
				end
			end
		end
		else if (!frame_ff.rw)
		begin
			if (frame_ff.bit_cnt == 3'h0)
			begin
				// held word is stable here: its request was answered long ago
				nxt_frame.shout = {sys_ff.rd_hold[6:0], 1'b0};
				nxt_frame.addr = next_addr;
				nxt_evt.rd_addr = next_addr;
				nxt_evt.rd_pop = 1'b1;
				nxt_evt.rd_tgl = ~evt_ff.rd_tgl;
			end
			else
				nxt_frame.shout = {frame_ff.shout[6:0], 1'b0};
		end
		else
		begin
			nxt_frame.shin = {frame_ff.shin[5:0], spi_sdi};
			if (frame_ff.bit_cnt == 3'h7)
			begin
				nxt_evt.wr_addr = frame_ff.addr;
				nxt_evt.wr_data = {frame_ff.shin, spi_sdi};
				nxt_evt.wr_tgl = ~evt_ff.wr_tgl;
				nxt_frame.addr = next_addr;
			end
		end
	end

	always_comb
	begin
		spi_sdo = 1'b0;
		if (!frame_ff.addr_phase && !frame_ff.rw)
			spi_sdo = (frame_ff.bit_cnt == 3'h0) ? sys_ff.rd_hold[7] : frame_ff.shout[7];
	end

	// select high clears the frame even though the serial clock is stopped
	always_ff @(posedge spi_sclk or posedge serial_select_n)
	begin
		if (serial_select_n)
			frame_ff <= '{addr_phase: 1'b1, default: '0};
		else
			frame_ff <= nxt_frame;
	end

	// toggles must survive frame ends, else a frame end fakes an event
	always_ff @(posedge spi_sclk or posedge reset)
	begin
		if (reset)
			evt_ff <= '0;
		else
			evt_ff <= nxt_evt;
	end

	// system side
	assign wr_ev   = sys_ff.wr_sync[1] ^ sys_ff.wr_sync[2];
	assign rd_ev   = sys_ff.rd_sync[1] ^ sys_ff.rd_sync[2];
	// only a byte really shown from the fifo is popped, none is lost
	assign buf_pop = rd_ev && evt_ff.rd_pop && sys_ff.held_valid;
	assign ta_hit  = sys_ff.ta_len[`HOPREG_TA_EN_BIT] && last_byte &&
		(bit_index == {1'b1, sys_ff.ta_len[`HOPREG_PHASE_HI:`HOPREG_PHASE_LO]});
	// widened before the product, so no channel and step pair can wrap
	assign hop_khz = 21'(sys_ff.hop_ch) * 21'(sys_ff.hop_step) * 21'(`HOPREG_HOP_UNIT_KHZ);

	// one write decoder per writable register, four in all
	for (genvar gw = 0; gw < 4; gw++)
	begin : g_wr_dec
		assign wr_hit[gw] = wr_ev && (evt_ff.wr_addr == REG_ADR[gw]);
	end

	// per-source gate; a source counts only while its enable is set
	for (genvar gi = 0; gi < 8; gi++)
	begin : g_irq
		assign irq_hit[gi] = irq_status[gi] & irq_enable[gi];
	end

	// unmapped addresses, an empty fifo and the two unused rx_thr bits read as zero
	always_comb
	begin
		rd_view = 8'h00;
		unique case (evt_ff.rd_addr)
			`HOPREG_ADR_HOP_CH:   rd_view = sys_ff.hop_ch;
			`HOPREG_ADR_HOP_STEP: rd_view = sys_ff.hop_step;
			`HOPREG_ADR_TA_LEN:   rd_view = sys_ff.ta_len;
			`HOPREG_ADR_RX_THR:   rd_view = {2'h0, sys_ff.rx_thr};
			`HOPREG_ADR_FIFO:     rd_view = buf_valid ? buf_data : 8'h00;
			default:              rd_view = 8'h00;
		endcase
	end

	// crc count fixed at two bytes; compliance bit takes it off the payload even with crc off
	always_comb
	begin
		if (sys_ff.ta_len[`HOPREG_LEN_COMP_BIT])
		begin
			len_frame = pkt_len;
			len_payload = pkt_len - `HOPREG_CRC_BYTES;
		end
		else
		begin
			len_payload = pkt_len;
			len_frame = pkt_len + (crc_enable ? `HOPREG_CRC_BYTES : 8'h00);
		end
	end

	always_comb
	begin
		nxt_sys = sys_ff;
		nxt_sys.wr_sync = {sys_ff.wr_sync[1:0], evt_ff.wr_tgl};
		nxt_sys.rd_sync = {sys_ff.rd_sync[1:0], evt_ff.rd_tgl};
		nxt_sys.load_pend = rd_ev;
		if (buf_pop)
			nxt_sys.held_valid = 1'b0;
		if (wr_hit[0])
			nxt_sys.hop_ch = evt_ff.wr_data;
		if (wr_hit[1])
			nxt_sys.hop_step = evt_ff.wr_data;
		if (wr_hit[2])
			nxt_sys.ta_len = evt_ff.wr_data;
		if (wr_hit[3])
			nxt_sys.rx_thr = evt_ff.wr_data[5:0];
		// one cycle after the request, so a pop has moved the head
		if (sys_ff.load_pend)
		begin
			nxt_sys.rd_hold = rd_view;
			nxt_sys.held_valid = (evt_ff.rd_addr == `HOPREG_ADR_FIFO) && buf_valid;
		end
		nxt_sys.carrier = nominal_khz + {3'h0, hop_khz};
		nxt_sys.frame = len_frame;
		nxt_sys.payload = len_payload;
		// one pulse per last byte; disabled turn-around never fires
		nxt_sys.ta_pulse = ta_hit && !sys_ff.ta_fired;
		if (!last_byte)
			nxt_sys.ta_fired = 1'b0;
		else if (ta_hit)
			nxt_sys.ta_fired = 1'b1;
		nxt_sys.irq_n = ~|irq_hit;
		nxt_sys.almost_full = ({{(8-LW){1'b0}}, buf_level} >= {2'h0, sys_ff.rx_thr});
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			sys_ff <= '0;
			sys_ff.hop_ch <= `HOPREG_RST_HOP_CH;
			sys_ff.hop_step <= `HOPREG_RST_HOP_STEP;
			sys_ff.ta_len <= `HOPREG_RST_TA_LEN;
			sys_ff.rx_thr <= `HOPREG_RST_RX_THR;
			sys_ff.irq_n <= 1'b1;
		end
		else
			sys_ff <= nxt_sys;
	end

	assign interrupt_out_n  = sys_ff.irq_n;
	assign carrier_khz      = sys_ff.carrier;
	assign payload_len      = sys_ff.payload;
	assign frame_len        = sys_ff.frame;
	assign turnaround_pulse = sys_ff.ta_pulse;
	assign rx_almost_full   = sys_ff.almost_full;
endmodule

// ==== verif/hopreg_asserts.sv ====
`timescale 1ns/10ps
module hopreg_asserts (
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire logic       serial_select_n,
	input wire logic       spi_sdo,
	input wire logic [7:0] pkt_len,
	input wire logic       crc_enable,
	input wire logic       last_byte,
	input wire logic [2:0] bit_index,
	input wire logic [7:0] irq_status,
	input wire logic [7:0] irq_enable,
	input wire logic       interrupt_out_n,
	input wire logic [7:0] payload_len,
	input wire logic [7:0] frame_len,
	input wire logic       turnaround_pulse
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	property p_irq_low;
		|(irq_status & irq_enable) |=> !interrupt_out_n;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("irq not low");
	property p_irq_high;
		!(|(irq_status & irq_enable)) |=> interrupt_out_n;
	endproperty
	a_irq_high: assert property (p_irq_high) else $error("irq not high");
	// past reset guard: lengths lag one cycle
	property p_len_plain;
		!$past(reset) && !$past(crc_enable) |-> frame_len == $past(pkt_len);
	endproperty
	a_len_plain: assert property (p_len_plain) else $error("frame len");
	property p_len_crc;
		!$past(reset) && $past(crc_enable) |-> frame_len == payload_len + 8'h02;
	endproperty
	a_len_crc: assert property (p_len_crc) else $error("crc len");
	property p_len_pay;
		!$past(reset) |-> payload_len == $past(pkt_len) || payload_len == $past(pkt_len) - 8'h02;
	endproperty
	a_len_pay: assert property (p_len_pay) else $error("payload len");
	property p_ta_cause;
		turnaround_pulse |-> $past(last_byte) && $past(bit_index[2]);
	endproperty
	a_ta_cause: assert property (p_ta_cause) else $error("stray turn pulse");
	property p_ta_once;
		turnaround_pulse |=> !turnaround_pulse;
	endproperty
	a_ta_once: assert property (p_ta_once) else $error("turn pulse long");
	property p_sdo_idle;
		serial_select_n && $past(serial_select_n) |-> !spi_sdo;
	endproperty
	a_sdo_idle: assert property (p_sdo_idle) else $error("sdo busy idle");
endmodule

bind hopreg_top hopreg_asserts u_chk (.clk_sys, .reset, .serial_select_n, .spi_sdo, .pkt_len,
	.crc_enable, .last_byte, .bit_index, .irq_status, .irq_enable, .interrupt_out_n,
	.payload_len, .frame_len, .turnaround_pulse);

// ==== verif/hopreg_host.sv ====
`timescale 1ns/10ps
module hopreg_host (
	output logic      spi_sclk,
	output logic      serial_select_n,
	output logic      spi_sdi,
	input wire logic  spi_sdo
);
	// sclk stands still low between frames
	initial
	begin
		spi_sclk = 1'b0;
		serial_select_n = 1'b1;
		spi_sdi = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			spi_sdi = tx[i];
			#6;
			rx[i] = spi_sdo;
			spi_sclk = 1'b1;
			#6;
			spi_sclk = 1'b0;
		end
	endtask
	// 130 ns gap: read byte needs 4 sys clocks to load
	task automatic frame(input logic [7:0] hdr, input logic [7:0] d0, input logic [7:0] d1,
		input int n, output logic [7:0] q0, output logic [7:0] q1);
		logic [7:0] junk;
		serial_select_n = 1'b0;
		#10;
		xfer(hdr, junk);
		#130;
		xfer(d0, q0);
		if (n > 1)
		begin
			#130;
			xfer(d1, q1);
		end
		#10;
		serial_select_n = 1'b1;
		spi_sdi = ~spi_sdi; // released line, no pull
		#100;
	endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench;
	logic        clk_sys, reset, spi_sclk, serial_select_n, spi_sdi, spi_sdo;
	logic        rx_valid, rx_ready, crc_enable, last_byte, interrupt_out_n;
	logic        turnaround_pulse, rx_almost_full;
	logic [2:0]  bit_index;
	logic [7:0]  rx_data, pkt_len, irq_status, irq_enable, payload_len, frame_len;
	logic [23:0] nominal_khz, carrier_khz;
	int          n_fail = 0;
	int          compares = 0;
	hopreg_top u_dut (.clk_sys, .reset, .spi_sclk, .serial_select_n, .spi_sdi, .spi_sdo,
		.rx_data, .rx_valid, .rx_ready, .nominal_khz, .pkt_len, .crc_enable, .last_byte,
		.bit_index, .irq_status, .irq_enable, .interrupt_out_n, .carrier_khz, .payload_len,
		.frame_len, .turnaround_pulse, .rx_almost_full);
	hopreg_host u_host (.spi_sclk, .serial_select_n, .spi_sdi, .spi_sdo);
	always #10 clk_sys = ~clk_sys;
	task automatic print_verdict;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q0, q1;
		u_host.frame({1'b1, a}, d, 8'h00, 1, q0, q1);
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		logic [7:0] q1;
		u_host.frame({1'b0, a}, 8'h00, 8'h00, 1, q, q1);
	endtask
	task automatic push(input logic [7:0] d);
		int n;
		@(negedge clk_sys);
		rx_data = d;
		rx_valid = 1'b1;
		for (n = 0; n < 8 && rx_ready !== 1'b1; n++)
			@(negedge clk_sys);
		if (n == 8)
		begin
			n_fail++;
			print_verdict();
		end
		@(negedge clk_sys);
		rx_valid = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic t_regs;
		logic [7:0] q;
		logic [6:0] adr [5] = '{7'h79, 7'h7A, 7'h7B, 7'h7E, 7'h10};
		logic [7:0] rst [5] = '{8'h00, 8'h00, 8'h7B, 8'h00, 8'h00};
		for (int i = 0; i < 5; i++)
		begin
			rd(adr[i], q);
			chk(24'(q), 24'(rst[i]));
		end
	endtask
	task automatic t_hop;
		logic [7:0] q0, q1;
		@(negedge clk_sys);
		nominal_khz = 24'h100000;
		u_host.frame(8'hF9, 8'h05, 8'h0C, 2, q0, q1);
		u_host.frame(8'h79, 8'h00, 8'h00, 2, q0, q1);
		chk(24'(q0), 24'h000005);
		chk(24'(q1), 24'h00000C);
		@(negedge clk_sys);
		chk(carrier_khz, 24'h100258);
	endtask
	task automatic t_len;
		@(negedge clk_sys);
		pkt_len = 8'h09;
		for (int m = 0; m < 4; m++)
		begin
			wr(7'h7B, m[1] ? 8'h80 : 8'h00);
			@(negedge clk_sys);
			crc_enable = m[0];
			repeat (2) @(negedge clk_sys);
			chk(24'(frame_len), m == 1 ? 24'h00000B : 24'h000009);
			chk(24'(payload_len), m[1] ? 24'h000007 : 24'h000009);
		end
	endtask
	task automatic t_turn;
		int hits;
		int at;
		for (int k = 0; k < 5; k++)
		begin
			wr(7'h7B, k < 4 ? 8'h04 | 8'(k) : 8'h00);
			hits = 0;
			at = 0;
			@(negedge clk_sys);
			last_byte = 1'b1;
			for (int j = 0; j < 10; j++)
			begin
				@(negedge clk_sys);
				if (turnaround_pulse === 1'b1)
				begin
					hits++;
					at = j - 1;
				end
				bit_index = 3'(j);
			end
			last_byte = 1'b0;
			chk(24'(hits), k < 4 ? 24'h000001 : 24'h000000);
			chk(24'(at), k < 4 ? 24'(4 + k) : 24'h000000);
		end
	endtask
	task automatic t_fifo;
		logic [7:0] q0, q1;
		wr(7'h7E, 8'hFF);
		rd(7'h7E, q0);
		chk(24'(q0), 24'h00003F);
		wr(7'h7E, 8'h02);
		push(8'hA5);
		chk(24'(rx_almost_full), 24'h000000);
		push(8'h5A);
		chk(24'(rx_ready), 24'h000000);
		chk(24'(rx_almost_full), 24'h000001);
		u_host.frame(8'h7F, 8'h00, 8'h00, 2, q0, q1);
		chk(24'(q0), 24'h0000A5);
		chk(24'(q1), 24'h00005A);
		rd(7'h7F, q0);
		chk(24'(q0), 24'h000000);
		chk(24'(rx_ready), 24'h000001);
	endtask
	task automatic t_irq;
		for (int i = 0; i < 8; i++)
		begin
			@(negedge clk_sys);
			irq_status = 8'h01 << i;
			irq_enable = 8'h01 << i;
			@(negedge clk_sys);
			chk(24'(interrupt_out_n), 24'h000000);
			irq_enable = ~irq_status;
			@(negedge clk_sys);
			chk(24'(interrupt_out_n), 24'h000001);
		end
	endtask
	task automatic t_rst;
		logic [7:0] q;
		wr(7'h79, 8'h3C);
		@(negedge clk_sys);
		reset = 1'b1;
		repeat (3) @(negedge clk_sys);
		reset = 1'b0;
		repeat (5) @(negedge clk_sys);
		chk(carrier_khz, 24'h100000);
		rd(7'h79, q);
		chk(24'(q), 24'h000000);
		rd(7'h7A, q);
		chk(24'(q), 24'h000000);
	endtask
	initial
	begin
		clk_sys = 1'b0;
		reset = 1'b1;
		{rx_data, rx_valid, nominal_khz, pkt_len, crc_enable} = '0;
		{last_byte, bit_index, irq_status, irq_enable} = '0;
		repeat (20) @(negedge clk_sys);
		reset = 1'b0;
		repeat (5) @(negedge clk_sys);
		t_regs();
		t_hop();
		t_len();
		t_turn();
		t_fifo();
		t_irq();
		t_rst();
		print_verdict();
	end
endmodule
